// [sim/ssbs_plant.sv]
// far-side model: brake test answer, motor run-up and braked run-down
`timescale 1ns/100ps
module ssbs_plant (
  // clock
  input wire logic aclk,
  // commands from the device
  input wire logic brake_test_req,
  input wire logic ramp_en,
  input wire logic brake_en,
  // scenario knobs
  input wire logic test_ok,
  input wire logic stall,
  // feedback to the device
  output logic brake_test_done,
  output logic brake_test_pass,
  output logic ramp_at_full_speed,
  output logic standstill_detected
);
  int spd = 0;
  // speed rises under the ramp, falls only under an effective brake
  always @(posedge aclk) begin
    brake_test_done <= brake_test_req;
    brake_test_pass <= brake_test_req && test_ok;
    if (ramp_en) begin
      spd <= (spd < 30) ? spd + 1 : spd;
    end else if (brake_en && !stall) begin
      spd <= (spd > 0) ? spd - 1 : 0;
    end
    ramp_at_full_speed <= ramp_en && spd >= 30;
    standstill_detected <= !ramp_en && spd == 0;
  end
endmodule

// [sim/testbench.sv]
// self-checking bench of the soft-start brake supervisor
`timescale 1ns/100ps
module testbench;
  localparam int TK = 4;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 0, led_yellow;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic start_button = 0, stop_button = 0, bimetal_contact_input = 0, thyristor_overtemp = 0;
  logic mains_sequence_ok = 1, mains_frequency_ok = 1, test_ok = 1, stall = 0;
  logic [1:0] thermistor_sensor_input = 0;
  logic [4:0] analog_fault_code = 0;
  logic [2:0] mains_phase_ok = 3'h7, device_phase_live = 0;
  logic standstill_detected, ramp_at_full_speed, brake_test_done, brake_test_pass;
  logic relay_overlong_brake, relay_ready, main_line_contactor, relay_standstill;
  logic bridge_relay, power_stage_en, ramp_en, brake_en, brake_test_req, led_green, led_red;
  logic [6:0] ob;
  int err_total = 0, comparisons = 0, n, k, c, p;
  int codes [12] = '{7, 2, 2, 2, 3, 1, 13, 12, 4, 5, 6, 11};
  assign ob = {led_red, relay_standstill, brake_en, bridge_relay, relay_overlong_brake, main_line_contactor, relay_ready};
  always #5 aclk = ~aclk;
  ssbs_top #(.TICK_CYCLES(TK), .BRAKE_WARN_TICKS(10), .BRAKE_MAX_TICKS(15), .BRAKE_CUT_TICKS(5), .PWRUP_TICKS(3)) dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .start_button, .stop_button, .bimetal_contact_input,
    .thermistor_sensor_input, .standstill_detected, .ramp_at_full_speed, .brake_test_done, .brake_test_pass,
    .thyristor_overtemp, .analog_fault_code, .mains_phase_ok, .mains_sequence_ok, .mains_frequency_ok,
    .device_phase_live, .relay_overlong_brake, .relay_ready, .main_line_contactor, .relay_standstill, .bridge_relay,
    .power_stage_en, .ramp_en, .brake_en, .brake_test_req, .led_green, .led_yellow, .led_red);
  ssbs_plant plant (.aclk, .brake_test_req, .ramp_en, .brake_en, .test_ok, .stall, .brake_test_done,
    .brake_test_pass, .ramp_at_full_speed, .standstill_detected);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic wt(input int b, input logic v, input int lim);
    n = 0;
    while (ob[b] !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
    if (ob[b] !== v) chk("wait", v, ob[b]);
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic rst();
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
  endtask
  task automatic go();
    start_button <= 1'h1;
    wt(1, 1, 100);
    start_button <= 1'h0;
  endtask
  task automatic halt();
    stop_button <= 1'h1;
    wt(4, 1, 100);
    stop_button <= 1'h0;
  endtask
  task automatic fset(input int f);
    case (f)
      0: test_ok <= 1'h0;
      1: bimetal_contact_input <= 1'h1;
      2: thermistor_sensor_input <= 2'h1;
      3: thermistor_sensor_input <= 2'h3;
      4: thermistor_sensor_input <= 2'h2;
      5: thyristor_overtemp <= 1'h1;
      6: analog_fault_code <= codes[6][4:0];
      7: device_phase_live <= 3'h3;
      8: mains_phase_ok <= 3'h6;
      9: mains_sequence_ok <= 1'h0;
      10: mains_frequency_ok <= 1'h0;
      default: start_button <= 1'h1;
    endcase
  endtask
  task automatic wrap_up();
    $display("counts: %0d compared, %0d mismatched", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    wrap_up();
  end
  initial begin
    void'($urandom(89512));
    codes[6] = 13 + $urandom % 5;
    rst();
    wt(0, 1, 200);
    chk("green", 1, led_green);
    axi_rd(8'h00);
    chk("ctrl reset", 1, rd);
    axi_rd(8'h10);
    chk("unmapped", 2, rsp);
    axi_wr(8'h00, $urandom & 32'hfffffffe);
    chk("ctrl write", 0, rsp);
    start_button <= 1'h1;
    repeat (10) @(posedge aclk);
    chk("start refused", 0, main_line_contactor);
    start_button <= 1'h0;
    axi_rd(8'h00);
    chk("ctrl clear", 0, rd);
    axi_wr(8'h00, $urandom | 32'h1);
    $display("test registers done");
    go();
    chk("standstill clr", 0, relay_standstill);
    wt(3, 1, 300);
    chk("ramp off", 0, ramp_en);
    chk("power on", 1, power_stage_en);
    axi_rd(8'h04);
    chk("state", 4, rd[2:0]);
    chk("yellow", {relay_standstill, main_line_contactor, relay_ready, relay_overlong_brake}, led_yellow);
    halt();
    chk("bridge off", 0, bridge_relay);
    wt(5, 1, 300);
    wt(4, 0, 100);
    chk("cut time", 1, n >= 4 * TK && n <= 6 * TK + 4);
    wt(1, 0, 8);
    $display("test start and brake done");
    stall <= 1'h1;
    for (k = 1; k <= 3; k++) begin
      go();
      chk("overlong clr", 0, relay_overlong_brake);
      wt(3, 1, 300);
      halt();
      if (k < 3) begin
        wt(2, 1, 100);
        chk("warn time", 1, n >= 9 * TK && n <= 11 * TK + 4);
        wt(1, 0, 100);
        chk("max time", 1, n >= 4 * TK && n <= 6 * TK + 4);
        chk("brake off", 0, brake_en);
      end else begin
        wt(0, 0, 100);
        axi_rd(8'h08);
        chk("err code", 9, rd);
        chk("contactor", 0, main_line_contactor);
      end
    end
    $display("test overlong brake done");
    for (k = 0; k < 12; k++) begin
      {stall, test_ok, bimetal_contact_input, thyristor_overtemp, start_button} <= 5'h08;
      {thermistor_sensor_input, analog_fault_code, device_phase_live} <= 10'h000;
      {mains_phase_ok, mains_sequence_ok, mains_frequency_ok} <= 5'h1f;
      if (k >= 7) fset(k);
      rst();
      if (k < 7) begin
        wt(0, 1, 200);
        if (k == 0) fset(k);
        go();
        if (k > 0) fset(k);
      end
      repeat (30) @(posedge aclk);
      axi_rd(8'h08);
      chk("fault code", codes[k], rd);
      chk("all off", 0, {relay_overlong_brake, relay_ready, main_line_contactor, relay_standstill,
        power_stage_en, bridge_relay, brake_en});
      if (k == 1) begin
        bimetal_contact_input <= 1'h0;
        n = 0;
        while (n < 2000) begin
          @(posedge aclk);
          n = led_red ? 0 : n + 1;
        end
        c = 0;
        p = 0;
        n = 0;
        while (n < 5000) begin
          @(posedge aclk);
          c += (led_red && !p);
          p = led_red;
          n = led_red ? 0 : n + 1;
        end
        chk("pulses", 2, c);
        axi_rd(8'h08);
        chk("still latched", 2, rd);
      end
    end
    $display("test faults done");
    wrap_up();
  end
endmodule

// [verilog/ssbs_flasher.sv]
// red error lamp: pulse bursts of the error code with a long pause
`timescale 1ns/100ps
module ssbs_flasher (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // millisecond tick and code to show
  input wire logic tick,
  input wire logic [4:0] code,
  // lamp
  output logic led
);
  typedef struct packed {
    logic [10:0] ms;
    logic [4:0] left;
    logic on;
  } ssbs_fl_t;
  ssbs_fl_t s_r;
  ssbs_fl_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (code == ssbs_pkg::E_NONE) begin
      s_nxt = '0;
    end else if (tick) begin
      if (s_r.ms != 11'h000) begin
        s_nxt.ms = s_r.ms - 11'h001;
      end else if (s_r.on) begin
        s_nxt.on = 1'b0;
        s_nxt.left = s_r.left - 5'h01;
        // dark pause after the last pulse of a burst
        s_nxt.ms = (s_r.left == 5'h01) ? 11'(ssbs_pkg::FLASH_PAUSE_TK - 1) : 11'(ssbs_pkg::FLASH_OFF_TK - 1); // R25
      end else begin
        s_nxt.on = 1'b1;
        s_nxt.left = (s_r.left == 5'h00) ? code : s_r.left; // R19
        s_nxt.ms = 11'(ssbs_pkg::FLASH_ON_TK - 1);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign led = s_r.on;

  a_dark_no_code: assert property (@(posedge aclk) disable iff (!aresetn)
    code == ssbs_pkg::E_NONE |=> !led) else $error("red lamp lit with no error"); // R19
  a_burst_pause: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(s_r.on) && s_r.left == 5'h00 |-> s_r.ms == 11'(ssbs_pkg::FLASH_PAUSE_TK - 1))
    else $error("burst not followed by long pause"); // R25
endmodule

// [verilog/ssbs_pkg.sv]
// constants and types shared by the soft-start brake supervisor
package ssbs_pkg;
  // clock and time base
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  // brake, start and lamp timing, figures in their own units
  localparam int BRAKE_WARN_S = 10;
  localparam int BRAKE_MAX_S = 15;
  localparam int BRAKE_CUT_MS = 500;
  localparam int PWRUP_MS = 100;
  localparam int BLINK_MS = 250;
  localparam int FLASH_ON_MS = 250;
  localparam int FLASH_OFF_MS = 250;
  localparam int FLASH_PAUSE_MS = 1500;
  // the same times as counts of millisecond ticks
  localparam int BRAKE_WARN_TK = BRAKE_WARN_S * 1000 / TICK_MS;
  localparam int BRAKE_MAX_TK = BRAKE_MAX_S * 1000 / TICK_MS;
  localparam int BRAKE_CUT_TK = BRAKE_CUT_MS / TICK_MS;
  localparam int PWRUP_TK = PWRUP_MS / TICK_MS;
  localparam int BLINK_TK = BLINK_MS / TICK_MS;
  localparam int FLASH_ON_TK = FLASH_ON_MS / TICK_MS;
  localparam int FLASH_OFF_TK = FLASH_OFF_MS / TICK_MS;
  localparam int FLASH_PAUSE_TK = FLASH_PAUSE_MS / TICK_MS;
  // overlong brake events before the latched error
  localparam logic [1:0] OVB_LIMIT = 2'h3;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ERR = 8'h08;
  localparam logic [7:0] REG_OVB = 8'h0c;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // thermistor sensor states
  localparam logic [1:0] TH_OK = 2'h0;
  localparam logic [1:0] TH_HOT = 2'h1;
  localparam logic [1:0] TH_SHORT = 2'h2;
  localparam logic [1:0] TH_OPEN = 2'h3;
  // error codes, shown as red pulse counts
  localparam logic [4:0] E_NONE = 5'h00;
  localparam logic [4:0] E_THYR = 5'h01;
  localparam logic [4:0] E_MOTOR_TEMP = 5'h02;
  localparam logic [4:0] E_SENS_SHORT = 5'h03;
  localparam logic [4:0] E_PHASE_FAIL = 5'h04;
  localparam logic [4:0] E_PHASE_SEQ = 5'h05;
  localparam logic [4:0] E_FREQ = 5'h06;
  localparam logic [4:0] E_BRAKE_CKT = 5'h07;
  localparam logic [4:0] E_SAFETY = 5'h08;
  localparam logic [4:0] E_OVERLONG = 5'h09;
  localparam logic [4:0] E_RAM = 5'h0a;
  localparam logic [4:0] E_RUN_STUCK = 5'h0b;
  localparam logic [4:0] E_NOT_SEP = 5'h0c;
  localparam logic [4:0] E_SEMI_OC = 5'h0d;
  localparam logic [4:0] E_BRAKE_OC = 5'h0e;
  localparam logic [4:0] E_RAMP_OC = 5'h0f;
  localparam logic [4:0] E_COMM = 5'h10;
  localparam logic [4:0] E_BRIDGE_OC = 5'h11;
  typedef enum logic [2:0] {S_POWERUP, S_READY, S_TEST, S_RAMP, S_RUN, S_BRAKE, S_HOLD, S_ERROR} ssbs_state_t;
endpackage

// [verilog/ssbs_top.sv]
// supervisory sequencer of the soft starter with dc brake
// Behaviour
// R1 - stop while running starts dc braking
// R2 - test brake circuit at start, fail aborts
// R3 - bridge ramp semiconductors at full speed
// R4 - overlong-brake relay after 10 s braking
// R5 - end braking and drop contactor at 15 s
// R6 - restart clears the overlong-brake relay
// R7 - third overlong brake latches error 9
// R8 - ready relay on once ready after power-up
// R9 - any error drops ready, power stage off
// R10 - contactor relay on at start, off at standstill
// R11 - no standstill: contactor off after safety time
// R12 - any fault drops contactor relay at once
// R13 - standstill relay set, cleared by start or error
// R14 - bimetal overtemperature: power off, relays off
// R15 - thermistor hot, short, open: all off
// R16 - temperature faults cleared only by power cycle
// R17 - green steady on, flashing in ramp, brake
// R18 - yellow lamp follows each relay contact
// R19 - red lamp flashes error code pulses
// R20 - codes 10 to 17 for further faults
// R21 - cut brake current 0.5 s after standstill
// R22 - power-up check of frequency, sequence, phases
// R23 - phases present at device raise error 12
// R24 - operator starts with start, brakes with stop
// R25 - long dark pause between code bursts
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module ssbs_top #(
  parameter int TICK_CYCLES = ssbs_pkg::TICK_CYC,
  parameter int BRAKE_WARN_TICKS = ssbs_pkg::BRAKE_WARN_TK,
  parameter int BRAKE_MAX_TICKS = ssbs_pkg::BRAKE_MAX_TK,
  parameter int BRAKE_CUT_TICKS = ssbs_pkg::BRAKE_CUT_TK,
  parameter int PWRUP_TICKS = ssbs_pkg::PWRUP_TK
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // operator buttons
  input wire logic start_button,
  input wire logic stop_button,
  // motor temperature
  input wire logic bimetal_contact_input,
  input wire logic [1:0] thermistor_sensor_input,
  // drive and brake feedback
  input wire logic standstill_detected,
  input wire logic ramp_at_full_speed,
  input wire logic brake_test_done,
  input wire logic brake_test_pass,
  input wire logic thyristor_overtemp,
  input wire logic [4:0] analog_fault_code,
  // mains sensing
  input wire logic [2:0] mains_phase_ok,
  input wire logic mains_sequence_ok,
  input wire logic mains_frequency_ok,
  input wire logic [2:0] device_phase_live,
  // relay outputs
  output logic relay_overlong_brake,
  output logic relay_ready,
  output logic main_line_contactor,
  output logic relay_standstill,
  // power stage
  output logic bridge_relay,
  output logic power_stage_en,
  output logic ramp_en,
  output logic brake_en,
  output logic brake_test_req,
  // lamps
  output logic led_green,
  output logic [3:0] led_yellow,
  output logic led_red
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int NIN = 23;

  typedef struct packed {
    logic [NIN-1:0] sy1;
    logic [NIN-1:0] sy2;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [13:0] ms;
    logic [7:0] blink_cnt;
    logic blink;
    ssbs_pkg::ssbs_state_t state;
    logic [4:0] err;
    logic [1:0] ovb_cnt;
    logic ctrl_en;
    logic rly_ovb;
    logic rly_rdy;
    logic rly_con;
    logic rly_sts;
    logic bridge;
    logic pwr_en;
    logic ramp;
    logic brake;
    logic test_req;
    logic led_g;
    logic [3:0] led_y;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ssbs_st_t;

  ssbs_st_t s_r;
  ssbs_st_t s_nxt;
  logic [NIN-1:0] pins;
  logic start_s, stop_s, bimetal_s, stand_s, full_s, tdone_s, tpass_s, thyr_s, seq_s, freq_s;
  logic [1:0] th_s;
  logic [2:0] mains_s, dev_s;
  logic [4:0] ana_s;
  logic [4:0] fault;
  logic start_take;

  function automatic logic two_live(input logic [2:0] p);
    two_live = (p[0] & p[1]) | (p[0] & p[2]) | (p[1] & p[2]);
  endfunction

  function automatic logic reg_mapped(input logic [7:0] a);
    reg_mapped = (a == ssbs_pkg::REG_CTRL) || (a == ssbs_pkg::REG_STATUS) ||
                 (a == ssbs_pkg::REG_ERR) || (a == ssbs_pkg::REG_OVB);
  endfunction

  assign pins = {start_button, stop_button, bimetal_contact_input, thermistor_sensor_input,
                 standstill_detected, ramp_at_full_speed, brake_test_done, brake_test_pass,
                 thyristor_overtemp, analog_fault_code, mains_phase_ok, mains_sequence_ok,
                 mains_frequency_ok, device_phase_live};
  assign {start_s, stop_s, bimetal_s, th_s, stand_s, full_s, tdone_s, tpass_s, thyr_s, ana_s,
          mains_s, seq_s, freq_s, dev_s} = s_r.sy2;
  assign start_take = (s_r.state == ssbs_pkg::S_READY) && start_s && s_r.ctrl_en;

  // continuous fault sources, lowest code first
  always_comb begin
    fault = ssbs_pkg::E_NONE;
    if (thyr_s) begin
      fault = ssbs_pkg::E_THYR; // R19
    end else if (bimetal_s || th_s == ssbs_pkg::TH_HOT || th_s == ssbs_pkg::TH_OPEN) begin
      fault = ssbs_pkg::E_MOTOR_TEMP; // R14 R15
    end else if (th_s == ssbs_pkg::TH_SHORT) begin
      fault = ssbs_pkg::E_SENS_SHORT; // R15
    end else if (ana_s != ssbs_pkg::E_NONE) begin
      fault = ana_s; // R20
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.sy1 = pins;
    s_nxt.sy2 = s_r.sy1;
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt == TW'(TICK_CYCLES - 1)) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
    end
    if (s_r.tick) begin
      if (s_r.blink_cnt == 8'(ssbs_pkg::BLINK_TK - 1)) begin
        s_nxt.blink_cnt = 8'h00;
        s_nxt.blink = !s_r.blink;
      end else begin
        s_nxt.blink_cnt = s_r.blink_cnt + 8'h01;
      end
      s_nxt.ms = s_r.ms + 14'h0001;
    end
    // sequencer
    case (s_r.state)
      ssbs_pkg::S_POWERUP: begin
        if (s_r.tick && s_r.ms == 14'(PWRUP_TICKS - 1)) begin
          if (mains_s != 3'h7) begin
            s_nxt.err = ssbs_pkg::E_PHASE_FAIL; // R22
          end else if (!seq_s) begin
            s_nxt.err = ssbs_pkg::E_PHASE_SEQ; // R22
          end else if (!freq_s) begin
            s_nxt.err = ssbs_pkg::E_FREQ; // R22
          end else if (start_s) begin
            s_nxt.err = ssbs_pkg::E_RUN_STUCK; // R20
          end else if (two_live(dev_s)) begin
            s_nxt.err = ssbs_pkg::E_NOT_SEP; // R23
          end else begin
            s_nxt.state = ssbs_pkg::S_READY;
            s_nxt.rly_rdy = 1'b1; // R8
          end
        end
      end
      ssbs_pkg::S_READY: begin
        if (two_live(dev_s)) begin
          s_nxt.err = ssbs_pkg::E_NOT_SEP; // R23
        end else if (start_take) begin
          s_nxt.state = ssbs_pkg::S_TEST; // R24
          s_nxt.rly_con = 1'b1; // R10
          s_nxt.rly_sts = 1'b0; // R13
          s_nxt.rly_ovb = 1'b0; // R6
          s_nxt.test_req = 1'b1; // R2
        end
      end
      ssbs_pkg::S_TEST: begin
        if (tdone_s) begin
          s_nxt.test_req = 1'b0;
          if (tpass_s) begin
            s_nxt.state = ssbs_pkg::S_RAMP;
            s_nxt.pwr_en = 1'b1;
            s_nxt.ramp = 1'b1;
          end else begin
            s_nxt.err = ssbs_pkg::E_BRAKE_CKT; // R2
          end
        end
      end
      ssbs_pkg::S_RAMP, ssbs_pkg::S_RUN: begin
        if (stop_s) begin
          s_nxt.state = ssbs_pkg::S_BRAKE; // R1
          s_nxt.ramp = 1'b0;
          s_nxt.bridge = 1'b0;
          s_nxt.brake = 1'b1; // R1
          s_nxt.ms = 14'h0000;
        end else if (s_r.state == ssbs_pkg::S_RAMP && full_s) begin
          s_nxt.state = ssbs_pkg::S_RUN;
          s_nxt.ramp = 1'b0;
          s_nxt.bridge = 1'b1; // R3
        end
      end
      ssbs_pkg::S_BRAKE: begin
        if (stand_s) begin
          s_nxt.state = ssbs_pkg::S_HOLD;
          s_nxt.rly_sts = 1'b1; // R13
          s_nxt.ms = 14'h0000;
        end else if (s_r.tick) begin
          if (s_r.ms == 14'(BRAKE_WARN_TICKS - 1)) begin
            s_nxt.rly_ovb = 1'b1; // R4
            s_nxt.ovb_cnt = s_r.ovb_cnt + 2'h1;
            if (s_r.ovb_cnt == ssbs_pkg::OVB_LIMIT - 2'h1) begin
              s_nxt.err = ssbs_pkg::E_OVERLONG; // R7
            end
          end
          if (s_r.ms == 14'(BRAKE_MAX_TICKS - 1)) begin
            s_nxt.state = ssbs_pkg::S_READY; // R5
            s_nxt.brake = 1'b0; // R5
            s_nxt.pwr_en = 1'b0;
            s_nxt.rly_con = 1'b0; // R11
          end
        end
      end
      ssbs_pkg::S_HOLD: begin
        if (s_r.tick && s_r.ms == 14'(BRAKE_CUT_TICKS - 1)) begin
          s_nxt.state = ssbs_pkg::S_READY;
          s_nxt.brake = 1'b0; // R21
          s_nxt.pwr_en = 1'b0;
          s_nxt.rly_con = 1'b0; // R10
        end
      end
      ssbs_pkg::S_ERROR: begin
        s_nxt.state = ssbs_pkg::S_ERROR; // R16
      end
      default: begin
        s_nxt.state = ssbs_pkg::S_ERROR;
      end
    endcase
    if (s_r.state != ssbs_pkg::S_ERROR && s_nxt.err == ssbs_pkg::E_NONE && fault != ssbs_pkg::E_NONE) begin
      s_nxt.err = fault; // R14 R15
    end
    // error mode: relays and power stage off except the overlong-brake relay on error 9, held until power cycle
    if (s_nxt.err != ssbs_pkg::E_NONE) begin
      s_nxt.state = ssbs_pkg::S_ERROR; // R16
      s_nxt.rly_rdy = 1'b0; // R9
      s_nxt.rly_con = 1'b0; // R12
      s_nxt.rly_sts = 1'b0; // R13
      s_nxt.rly_ovb = s_nxt.rly_ovb && s_nxt.err == ssbs_pkg::E_OVERLONG; // R4 R14
      s_nxt.pwr_en = 1'b0; // R9
      s_nxt.bridge = 1'b0;
      s_nxt.ramp = 1'b0;
      s_nxt.brake = 1'b0;
      s_nxt.test_req = 1'b0;
    end
    s_nxt.led_g = (s_r.state == ssbs_pkg::S_RAMP || s_r.state == ssbs_pkg::S_BRAKE ||
                   s_r.state == ssbs_pkg::S_HOLD) ? s_r.blink : 1'b1; // R17
    s_nxt.led_y = {s_nxt.rly_sts, s_nxt.rly_con, s_nxt.rly_rdy, s_nxt.rly_ovb}; // R18
    // axi4-lite write
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_nxt.aw_got && s_nxt.w_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = reg_mapped(s_nxt.awaddr) ? ssbs_pkg::RESP_OKAY : ssbs_pkg::RESP_SLVERR;
      if (s_nxt.awaddr == ssbs_pkg::REG_CTRL && s_nxt.wstrb[0]) begin
        s_nxt.ctrl_en = s_nxt.wdata[0];
      end
    end
    s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
    // axi4-lite read
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = reg_mapped(s_axi_araddr) ? ssbs_pkg::RESP_OKAY : ssbs_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        ssbs_pkg::REG_CTRL: s_nxt.rdata = {31'h0, s_r.ctrl_en};
        ssbs_pkg::REG_STATUS: s_nxt.rdata = {20'h0, s_r.pwr_en, s_r.ramp, s_r.brake, s_r.bridge,
                                             s_r.led_y, 1'b0, s_r.state};
        ssbs_pkg::REG_ERR: s_nxt.rdata = {27'h0, s_r.err};
        ssbs_pkg::REG_OVB: s_nxt.rdata = {30'h0, s_r.ovb_cnt};
        default: s_nxt.rdata = 32'h0;
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.ctrl_en <= ssbs_pkg::CTRL_EN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ssbs_flasher u_flasher (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(s_r.tick),
    .code(s_r.err),
    .led(led_red)
  );

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign relay_overlong_brake = s_r.rly_ovb;
  assign relay_ready = s_r.rly_rdy;
  assign main_line_contactor = s_r.rly_con;
  assign relay_standstill = s_r.rly_sts;
  assign bridge_relay = s_r.bridge;
  assign power_stage_en = s_r.pwr_en;
  assign ramp_en = s_r.ramp;
  assign brake_en = s_r.brake;
  assign brake_test_req = s_r.test_req;
  assign led_green = s_r.led_g;
  assign led_yellow = s_r.led_y;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_stop_brakes: assert property ((s_r.state == ssbs_pkg::S_RUN) && stop_s && fault == ssbs_pkg::E_NONE
    |=> brake_en && !bridge_relay) else $error("stop did not start braking"); // R1
  a_test_fail: assert property ((s_r.state == ssbs_pkg::S_TEST) && tdone_s && !tpass_s
    |=> s_r.err == ssbs_pkg::E_BRAKE_CKT && !power_stage_en) else $error("brake test fail ignored"); // R2
  a_bridge_run: assert property (bridge_relay |-> s_r.state == ssbs_pkg::S_RUN)
    else $error("bridge closed outside run"); // R3
  a_warn_relay: assert property ((s_r.state == ssbs_pkg::S_BRAKE) && s_r.tick && !stand_s &&
    s_r.ms == 14'(BRAKE_WARN_TICKS - 1) |=> relay_overlong_brake) else $error("overlong relay late"); // R4
  a_brake_limit: assert property ((s_r.state == ssbs_pkg::S_BRAKE) |-> s_r.ms < 14'(BRAKE_MAX_TICKS))
    else $error("braking beyond limit"); // R5
  a_restart_clear: assert property (start_take |=> !relay_overlong_brake && main_line_contactor)
    else $error("restart left overlong relay"); // R6
  a_third_latch: assert property ((s_r.ovb_cnt == ssbs_pkg::OVB_LIMIT) |-> s_r.err == ssbs_pkg::E_OVERLONG)
    else $error("third overlong not latched"); // R7
  a_err_off: assert property ((s_r.err != ssbs_pkg::E_NONE) |-> !relay_ready && !main_line_contactor &&
    !relay_standstill && (!relay_overlong_brake || s_r.err == ssbs_pkg::E_OVERLONG) && !power_stage_en)
    else $error("error left outputs on"); // R9
  a_err_hold: assert property ((s_r.err != ssbs_pkg::E_NONE) |=> $stable(s_r.err) [*4])
    else $error("error cleared without power cycle"); // R16
  a_cut_delay: assert property ($rose(s_r.state == ssbs_pkg::S_HOLD) |-> brake_en [*3])
    else $error("brake cut too early"); // R21
  a_not_sep: assert property ((s_r.state == ssbs_pkg::S_READY) && two_live(dev_s)
    |=> s_r.err == ssbs_pkg::E_NOT_SEP) else $error("live phases not flagged"); // R23
  c_start: cover property (start_take ##[1:20] s_r.state == ssbs_pkg::S_RAMP);
  c_brake_stand: cover property (s_r.state == ssbs_pkg::S_BRAKE ##1 s_r.state == ssbs_pkg::S_HOLD);
  c_error: cover property ($rose(s_r.state == ssbs_pkg::S_ERROR));
endmodule
